// ---- verilog/tcc_pkg.sv ----
package tcc_pkg;

	// Register offsets on the byte-wide register port.
	localparam logic [3:0] ADDR_CTRL      = 4'h0;
	localparam logic [3:0] ADDR_STATUS    = 4'h1;
	localparam logic [3:0] ADDR_EVENTS    = 4'h2;
	localparam logic [3:0] ADDR_CHMODE    = 4'h3;
	localparam logic [3:0] ADDR_CMPSEL    = 4'h4;
	localparam logic [3:0] ADDR_PORT      = 4'h5;
	localparam logic [3:0] ADDR_COUNT_LO  = 4'h6;
	localparam logic [3:0] ADDR_COUNT_HI  = 4'h7;
	localparam logic [3:0] ADDR_CHAN_BASE = 4'h8;

	// Field positions in the timer control register.
	localparam int CTRL_SRC_LSB   = 0;
	localparam int CTRL_PRESC_BIT = 2;
	localparam int CTRL_RLD_EN    = 3;
	localparam int CTRL_RLD_MODE  = 4;
	localparam int CTRL_EDGE_BIT  = 5;
	localparam int CTRL_EXEN_BIT  = 6;

	// Field positions in the status register.
	localparam int STAT_OVF_BIT = 0;
	localparam int STAT_EXF_BIT = 1;

	// Values after reset, and the all-ones count maximum.
	localparam logic [7:0]  CTRL_RST   = 8'h00;
	localparam logic [7:0]  CHMODE_RST = 8'h00;
	localparam logic [3:0]  CMPSEL_RST = 4'h0;
	localparam logic [15:0] COUNT_RST  = 16'h0000;
	localparam logic [15:0] COUNT_MAX  = 16'hFFFF;

	// Oscillator periods per machine cycle, as a last count value.
	localparam logic [2:0] MC_LAST = 3'h5;

	// Count input source.
	typedef enum logic [1:0] {
		SRC_STOP  = 2'b00,
		SRC_TIMER = 2'b01,
		SRC_GATED = 2'b10,
		SRC_EVENT = 2'b11
	} tcc_src_type;

	// Per-channel function.
	typedef enum logic [1:0] {
		CH_OFF      = 2'b00,
		CH_COMPARE  = 2'b01,
		CH_CAPT_PIN = 2'b10,
		CH_CAPT_SW  = 2'b11
	} tcc_chmode_type;

endpackage

// ---- verilog/tcc_timer2.sv ----
// Functional notes
// - 16-bit count; rollover from all ones sets the overflow flag.
// - Timer source counts at one sixth or one twelfth of the clock.
// - Gated source counts only while the sampled gate is high.
// - The gate input is sampled once every machine cycle.
// - Event source counts each sampled falling edge, detected over two cycles.
// - Reload mode 0 loads the reload register on every rollover.
// - Reload mode 1 loads the reload register on a trigger falling edge.
// - Trigger falling edge sets external reload flag only when enabled.
// - Each compare channel compares its value with the count.
// - Compare mode 0 drives the output high on a match.
// - Compare mode 0 returns the output low on overflow.
// - Compare mode 0 ignores software writes to the output latch.
// - Compare mode 1 writes a shadow copied to the output on match.
// - All four channel registers can latch the full 16-bit count.
// - Capture mode 0 latches channels 1 to 3 on rising pin edges.
// - Capture mode 0 on the reload register uses the selected edge.
// - Capture mode 1 latches the count the cycle after a low-byte write.
// - Software-triggered captures raise no event flag.
module tcc_timer2 #(
	parameter int CH = 4
) (
	// Clock and reset.
	input  wire logic          sys_clk,
	input  wire logic          rst,
	// Register port.
	input  wire logic [3:0]    regAddr,
	input  wire logic [7:0]    regWrData,
	input  wire logic          regWrEn,
	input  wire logic          regRdEn,
	output logic      [7:0]    regRdData,
	// Pins.
	input  wire logic          gateEventIn,
	input  wire logic          reloadTriggerIn,
	input  wire logic [CH-1:0] captureIn,
	output logic      [CH-1:0] compareOut,
	// Flag levels.
	output logic               overflowFlag,
	output logic               externalReloadFlag
);

	localparam int SW = CH + 2;

	logic [7:0]    ctrl_q;
	logic [7:0]    chMode_q;
	logic [3:0]    cmpSel_q;
	logic [15:0]   cnt_q;
	logic          cntMoved_q;
	logic [2:0]    mcCnt_q;
	logic          half_q;
	logic [SW-1:0] syncA_q;
	logic [SW-1:0] syncB_q;
	logic [SW-1:0] pinPrev_q;
	logic          gateSamp_q;
	logic          evSamp_q;
	logic          evPrev_q;
	logic          ovfFlag_q;
	logic          exfFlag_q;
	logic [7:0]    events_q;
	logic [7:0]    rdData_q;
	logic [7:0]    rdMux;
	logic          mcEn;
	logic          tick;
	logic          ovf;
	logic          trigFall;
	logic          reloadPin;
	logic          wrCntLo;
	logic          wrCntHi;
	logic          wrCtrl;
	logic          wrPort;
	logic          gateSync;
	logic          trigSync;
	logic [CH-1:0] capSync;
	logic [CH-1:0] capRise;
	logic [CH-1:0] capFall;
	logic [CH-1:0] matchEv;
	logic [CH-1:0] capEv;
	logic [CH-1:0] outBit;
	logic [15:0]   chanVal [CH];
	logic [1:0]    src;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	// Write decode for shared registers.
	assign wrCtrl  = regWrEn && regAddr == tcc_pkg::ADDR_CTRL;
	assign wrPort  = regWrEn && regAddr == tcc_pkg::ADDR_PORT;
	assign wrCntLo = regWrEn && regAddr == tcc_pkg::ADDR_COUNT_LO;
	assign wrCntHi = regWrEn && regAddr == tcc_pkg::ADDR_COUNT_HI;

	// Configuration registers; reset stops the timer and channels.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrl_q   <= tcc_pkg::CTRL_RST;
			chMode_q <= tcc_pkg::CHMODE_RST;
			cmpSel_q <= tcc_pkg::CMPSEL_RST;
		end else begin
			if (wrCtrl) begin
				ctrl_q <= regWrData;
			end
			if (regWrEn && regAddr == tcc_pkg::ADDR_CHMODE) begin
				chMode_q <= regWrData;
			end
			if (regWrEn && regAddr == tcc_pkg::ADDR_CMPSEL) begin
				cmpSel_q <= regWrData[3:0];
			end
		end
	end

	assign src = ctrl_q[tcc_pkg::CTRL_SRC_LSB +: 2];

	// Machine cycle divider: one enable pulse every six clocks.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mcCnt_q <= 3'h0;
			half_q  <= 1'b0;
		end else if (mcEn) begin
			mcCnt_q <= 3'h0;
			half_q  <= ~half_q;
		end else begin
			mcCnt_q <= mcCnt_q + 3'h1;
		end
	end
	assign mcEn = mcCnt_q == tcc_pkg::MC_LAST;

	mcPeriod_a: assert property (mcEn |=> !mcEn [*5] ##1 mcEn)
		else $error("Machine cycle enable is not every six clocks.");

	// Two-stage synchronisers for every pin input.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			syncA_q   <= '0;
			syncB_q   <= '0;
			pinPrev_q <= '0;
		end else begin
			syncA_q   <= {captureIn, reloadTriggerIn, gateEventIn};
			syncB_q   <= syncA_q;
			pinPrev_q <= syncB_q;
		end
	end
	assign gateSync = syncB_q[0];
	assign trigSync = syncB_q[1];
	assign capSync  = syncB_q[SW-1:2];
	assign trigFall = pinPrev_q[1] && !trigSync;
	assign capRise  = ~pinPrev_q[SW-1:2] & capSync;
	assign capFall  = pinPrev_q[SW-1:2] & ~capSync;

	// Gate and event samples, taken once per machine cycle.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			gateSamp_q <= 1'b0;
			evSamp_q   <= 1'b0;
			evPrev_q   <= 1'b0;
		end else if (mcEn) begin
			gateSamp_q <= gateSync;
			evSamp_q   <= gateSync;
			evPrev_q   <= evSamp_q;
		end
	end

	// Count enable for each source.
	always_comb begin
		unique case (src)
			tcc_pkg::SRC_TIMER: begin
				tick = mcEn && (!ctrl_q[tcc_pkg::CTRL_PRESC_BIT] || half_q);
			end
			tcc_pkg::SRC_GATED: begin
				tick = mcEn && gateSamp_q &&
					(!ctrl_q[tcc_pkg::CTRL_PRESC_BIT] || half_q);
			end
			tcc_pkg::SRC_EVENT: begin
				tick = mcEn && evPrev_q && !evSamp_q;
			end
			tcc_pkg::SRC_STOP: begin
				tick = 1'b0;
			end
		endcase
	end

	gateStop_a: assert property (
		src == tcc_pkg::SRC_GATED && !gateSamp_q |-> !tick)
		else $error("Gated timer counted while the gate was low.");

	assign ovf       = tick && cnt_q == tcc_pkg::COUNT_MAX;
	assign reloadPin = trigFall && ctrl_q[tcc_pkg::CTRL_RLD_EN] &&
		ctrl_q[tcc_pkg::CTRL_RLD_MODE];

	// Count register: software byte write, pin reload, then counting.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt_q      <= tcc_pkg::COUNT_RST;
			cntMoved_q <= 1'b0;
		end else begin
			cntMoved_q <= tick || reloadPin || wrCntLo || wrCntHi;
			if (wrCntLo) begin
				cnt_q[7:0] <= regWrData;
			end else if (wrCntHi) begin
				cnt_q[15:8] <= regWrData;
			end else if (reloadPin) begin
				cnt_q <= chanVal[0];
			end else if (tick) begin
				if (ovf && ctrl_q[tcc_pkg::CTRL_RLD_EN] &&
					!ctrl_q[tcc_pkg::CTRL_RLD_MODE]) begin
					cnt_q <= chanVal[0];
				end else begin
					cnt_q <= cnt_q + 16'h0001;
				end
			end
		end
	end

	countStep_a: assert property (
		tick && !ovf && !reloadPin && !wrCntLo && !wrCntHi
		|=> cnt_q == $past(cnt_q) + 16'h0001)
		else $error("Count did not advance by one on a count enable.");

	eventEdge_a: assert property (
		src == tcc_pkg::SRC_EVENT && mcEn && evPrev_q && !evSamp_q &&
		!reloadPin && !wrCntLo && !wrCntHi |=> cnt_q != $past(cnt_q))
		else $error("Event falling edge was not counted.");

	reloadOvf_a: assert property (
		ovf && ctrl_q[tcc_pkg::CTRL_RLD_EN] &&
		!ctrl_q[tcc_pkg::CTRL_RLD_MODE] && !wrCntLo && !wrCntHi
		|=> cnt_q == $past(chanVal[0]))
		else $error("Rollover did not reload the count.");

	reloadPin_a: assert property (
		reloadPin && !wrCntLo && !wrCntHi |=> cnt_q == $past(chanVal[0]))
		else $error("Trigger edge did not reload the count.");

	// Overflow and external reload flags; set wins over a clear.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ovfFlag_q <= 1'b0;
			exfFlag_q <= 1'b0;
		end else begin
			if (ovf) begin
				ovfFlag_q <= 1'b1;
			end else if (regWrEn && regAddr == tcc_pkg::ADDR_STATUS &&
				regWrData[tcc_pkg::STAT_OVF_BIT]) begin
				ovfFlag_q <= 1'b0;
			end
			if (trigFall && ctrl_q[tcc_pkg::CTRL_EXEN_BIT]) begin
				exfFlag_q <= 1'b1;
			end else if (regWrEn && regAddr == tcc_pkg::ADDR_STATUS &&
				regWrData[tcc_pkg::STAT_EXF_BIT]) begin
				exfFlag_q <= 1'b0;
			end
		end
	end
	assign overflowFlag       = ovfFlag_q;
	assign externalReloadFlag = exfFlag_q;

	ovfFlag_a: assert property (ovf |=> ovfFlag_q)
		else $error("Overflow did not set the overflow flag.");

	extFlag_a: assert property (
		!trigFall || !ctrl_q[tcc_pkg::CTRL_EXEN_BIT] ##0 !exfFlag_q
		|=> !$rose(exfFlag_q))
		else $error("External reload flag set without an enabled edge.");

	// Per-channel compare and capture logic.
	for (genvar i = 0; i < CH; i++) begin : g_ch
		logic [1:0]  mode;
		logic [15:0] val_q;
		logic        pend_q;
		logic        shadow_q;
		logic        out_q;
		logic        wrLo;
		logic        wrHi;
		logic        pinCap;
		logic        match;

		assign mode = chMode_q[2*i +: 2];
		assign wrLo = regWrEn &&
			regAddr == tcc_pkg::ADDR_CHAN_BASE + 4'(2*i);
		assign wrHi = regWrEn &&
			regAddr == tcc_pkg::ADDR_CHAN_BASE + 4'(2*i+1);
		if (i == 0) begin : g_rld
			assign pinCap = ctrl_q[tcc_pkg::CTRL_EDGE_BIT] ?
				capRise[i] : capFall[i];
		end else begin : g_cc
			assign pinCap = capRise[i];
		end
		assign capEv[i] = mode == tcc_pkg::CH_CAPT_PIN && pinCap;
		assign match    = mode == tcc_pkg::CH_COMPARE && cntMoved_q &&
			cnt_q == val_q;
		assign matchEv[i] = match;

		// Channel value: captures take the whole count at once.
		always_ff @(posedge sys_clk or posedge rst) begin
			if (rst) begin
				val_q  <= tcc_pkg::COUNT_RST;
				pend_q <= 1'b0;
			end else begin
				pend_q <= wrLo && mode == tcc_pkg::CH_CAPT_SW;
				if (capEv[i] || pend_q) begin
					val_q <= cnt_q;
				end else if (wrLo && mode != tcc_pkg::CH_CAPT_SW) begin
					val_q[7:0] <= regWrData;
				end else if (wrHi) begin
					val_q[15:8] <= regWrData;
				end
			end
		end
		assign chanVal[i] = val_q;

		// Output latch and shadow latch.
		always_ff @(posedge sys_clk or posedge rst) begin
			if (rst) begin
				shadow_q <= 1'b0;
				out_q    <= 1'b0;
			end else begin
				if (wrPort) begin
					shadow_q <= regWrData[i];
				end
				if (mode == tcc_pkg::CH_COMPARE) begin
					if (!cmpSel_q[i]) begin
						// Writes have no path here in mode 0.
						if (match) begin
							out_q <= 1'b1;
						end else if (ovf) begin
							out_q <= 1'b0;
						end
					end else if (match) begin
						out_q <= shadow_q;
					end
				end else if (wrPort) begin
					out_q <= regWrData[i];
				end
			end
		end
		assign outBit[i] = out_q;

		cmpRise_a: assert property (
			match && !cmpSel_q[i] |=> out_q)
			else $error("Compare mode 0 match did not raise the output.");

		cmpFall_a: assert property (
			mode == tcc_pkg::CH_COMPARE && !cmpSel_q[i] && ovf && !match
			|=> !out_q)
			else $error("Compare mode 0 overflow did not lower output.");

		swCapture_a: assert property (
			wrLo && mode == tcc_pkg::CH_CAPT_SW && !capEv[i]
			|=> ##1 val_q == $past(cnt_q))
			else $error("Software capture did not latch the count.");
	end

	// Match flags in the low nibble, pin capture flags in the high.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			events_q <= 8'h00;
		end else begin
			events_q <= ({capEv, matchEv}) | (events_q &
				~((regWrEn && regAddr == tcc_pkg::ADDR_EVENTS) ?
				regWrData : 8'h00));
		end
	end

	assign compareOut = outBit;

	// Read multiplexer; data stands only in the cycle after the strobe.
	always_comb begin
		rdMux = 8'h00;
		unique case (regAddr)
			tcc_pkg::ADDR_CTRL: begin
				rdMux = ctrl_q;
			end
			tcc_pkg::ADDR_STATUS: begin
				rdMux = {6'h00, exfFlag_q, ovfFlag_q};
			end
			tcc_pkg::ADDR_EVENTS: begin
				rdMux = events_q;
			end
			tcc_pkg::ADDR_CHMODE: begin
				rdMux = chMode_q;
			end
			tcc_pkg::ADDR_CMPSEL: begin
				rdMux = {4'h0, cmpSel_q};
			end
			tcc_pkg::ADDR_PORT: begin
				rdMux = {4'h0, outBit};
			end
			tcc_pkg::ADDR_COUNT_LO: begin
				rdMux = cnt_q[7:0];
			end
			tcc_pkg::ADDR_COUNT_HI: begin
				rdMux = cnt_q[15:8];
			end
			default: begin
				if (regAddr[0]) begin
					rdMux = chanVal[regAddr[2:1]][15:8];
				end else begin
					rdMux = chanVal[regAddr[2:1]][7:0];
				end
			end
		endcase
	end

	// Read data register.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rdData_q <= 8'h00;
		end else begin
			rdData_q <= regRdEn ? rdMux : 8'h00;
		end
	end
	assign regRdData = rdData_q;

endmodule

// ---- verif/tcc_pin_model.sv ----
module tcc_pin_model (
	// Clock.
	input  wire logic       sys_clk,
	// Pins driven toward the timer.
	output logic            gateEventIn,
	output logic            reloadTriggerIn,
	output logic [3:0]      captureIn
);
	timeunit 1ns;
	timeprecision 1ps;

	// Clocks that every level is held, two machine cycles.
	localparam int HOLD = 12;

	// Pins idle with gate and trigger high and capture pins low.
	initial begin
		gateEventIn = 1'h1;
		reloadTriggerIn = 1'h1;
		captureIn = 4'h0;
	end

	// Pin index 0 to 3 is a capture pin, 4 the gate, 5 the trigger.
	task automatic setPin(input int idx, input logic v);
		@(posedge sys_clk);
		if (idx < 4) begin
			captureIn[idx] <= v;
		end else if (idx == 4) begin
			gateEventIn <= v;
		end else begin
			reloadTriggerIn <= v;
		end
		repeat (HOLD) @(posedge sys_clk);
	endtask
endmodule

// ---- verif/tb_top.sv ----
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	// Clock, reset and register port.
	logic        sysClk;
	logic        rst;
	logic [3:0]  regAddr;
	logic [7:0]  regWrData;
	logic        regWrEn;
	logic        regRdEn;
	logic [7:0]  regRdData;
	// Pins and flags.
	logic        gateEventIn;
	logic        reloadTriggerIn;
	logic [3:0]  captureIn;
	logic [3:0]  compareOut;
	logic        overflowFlag;
	logic        externalReloadFlag;
	logic [4:0]  obs;
	int          failures;
	int          totalChecks;
	logic [15:0] w;
	logic [15:0] v;
	logic [7:0]  b;

	// Outputs gathered so that one wait task can watch any of them.
	assign obs = {overflowFlag, compareOut};

	// The clock toggles every half period of 4 ns.
	always #4 sysClk = ~sysClk;

	tcc_timer2 tcc_timer2_inst (
		.sys_clk            (sysClk),
		.rst                (rst),
		.regAddr            (regAddr),
		.regWrData          (regWrData),
		.regWrEn            (regWrEn),
		.regRdEn            (regRdEn),
		.regRdData          (regRdData),
		.gateEventIn        (gateEventIn),
		.reloadTriggerIn    (reloadTriggerIn),
		.captureIn          (captureIn),
		.compareOut         (compareOut),
		.overflowFlag       (overflowFlag),
		.externalReloadFlag (externalReloadFlag)
	);

	tcc_pin_model tcc_pin_model_inst (
		.sys_clk         (sysClk),
		.gateEventIn     (gateEventIn),
		.reloadTriggerIn (reloadTriggerIn),
		.captureIn       (captureIn)
	);

	// Register port cycles, one strobe cycle each.
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sysClk);
		regAddr <= a;
		regWrData <= d;
		regWrEn <= 1'h1;
		@(posedge sysClk);
		regWrEn <= 1'h0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge sysClk);
		regAddr <= a;
		regRdEn <= 1'h1;
		@(posedge sysClk);
		regRdEn <= 1'h0;
		#1;
		d = regRdData;
	endtask

	// Sixteen-bit values travel low byte at the even address first.
	task automatic wr16(input logic [3:0] a, input logic [15:0] v);
		wr(a, v[7:0]);
		wr(a | 4'h1, v[15:8]);
	endtask

	task automatic rd16(input logic [3:0] a, output logic [15:0] v);
		rd(a, v[7:0]);
		rd(a | 4'h1, v[15:8]);
	endtask

	// Comparisons count every check and report each mismatch.
	task automatic chkWord(input logic [15:0] g, input logic [15:0] e);
		totalChecks++;
		if (g !== e) begin
			failures++;
			$display("ERROR at %0t: value %h, expected %h", $time, g, e);
		end
	endtask

	task automatic chkBit(input logic g, input logic e);
		totalChecks++;
		if (g !== e) begin
			failures++;
			$display("ERROR at %0t: flag %b, expected %b", $time, g, e);
		end
	endtask

	// Count advance between two reads whose strobes are n+4 clocks apart.
	task automatic countDiff(input int n, output logic [15:0] d);
		logic [15:0] a;
		logic [15:0] c;
		rd16(tcc_pkg::ADDR_COUNT_LO, a);
		repeat (n) @(posedge sysClk);
		rd16(tcc_pkg::ADDR_COUNT_LO, c);
		d = c - a;
	endtask

	// Waits a bounded time for an output to reach a level, then checks it.
	task automatic waitObs(input int i, input logic v);
		int k;
		k = 0;
		while (obs[i] !== v && k < 300) begin
			@(posedge sysClk);
			#1;
			k++;
		end
		chkBit(obs[i], v);
	endtask

	task automatic wrap_up();
		$display("checks %0d failures %0d", totalChecks, failures);
		if (failures == 0 && totalChecks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// A hang is cut short long after the tests should have ended.
	initial begin
		#200us;
		failures++;
		wrap_up();
	end

	// Main sequence of tests.
	initial begin
		sysClk = 1'h0;
		rst = 1'h1;
		regAddr = 4'h0;
		regWrData = 8'h00;
		regWrEn = 1'h0;
		regRdEn = 1'h0;
		failures = 0;
		totalChecks = 0;
		repeat (4) @(posedge sysClk);
		rst <= 1'h0;
		// Every shared register, the overflow flag and the compare outputs are zero after reset.
		for (int i = 0; i < 8; i++) begin
			rd(4'(i), b);
			chkWord({8'h00, b}, 16'h0000);
		end
		chkWord({11'h000, obs}, 16'h0000);
		// Timer rate at one sixth and one twelfth.
		wr16(tcc_pkg::ADDR_COUNT_LO, 16'h0010);
		wr(tcc_pkg::ADDR_CTRL, 8'h01);
		countDiff(8, w);
		chkWord(w, 16'h0002);
		wr(tcc_pkg::ADDR_CTRL, 8'h05);
		countDiff(8, w);
		chkWord(w, 16'h0001);
		// Gated timer counts only with the gate high.
		wr(tcc_pkg::ADDR_CTRL, 8'h02);
		repeat (24) @(posedge sysClk);
		countDiff(20, w);
		chkWord(w, 16'h0004);
		tcc_pin_model_inst.setPin(4, 1'h0);
		countDiff(20, w);
		chkWord(w, 16'h0000);
		// Event counter counts three falling edges.
		wr(tcc_pkg::ADDR_CTRL, 8'h03);
		tcc_pin_model_inst.setPin(4, 1'h1);
		rd16(tcc_pkg::ADDR_COUNT_LO, w);
		for (int i = 0; i < 3; i++) begin
			tcc_pin_model_inst.setPin(4, 1'h0);
			tcc_pin_model_inst.setPin(4, 1'h1);
		end
		rd16(tcc_pkg::ADDR_COUNT_LO, v);
		chkWord(16'(v - w), 16'h0003);
		// Pin and software captures with the timer stopped.
		wr(tcc_pkg::ADDR_CTRL, 8'h00);
		wr16(4'h8, 16'h0000);
		wr(tcc_pkg::ADDR_CHMODE, 8'h8E);
		wr(tcc_pkg::ADDR_EVENTS, 8'hFF);
		wr16(tcc_pkg::ADDR_COUNT_LO, 16'h1234);
		tcc_pin_model_inst.setPin(3, 1'h1);
		rd16(4'hE, w);
		chkWord(w, 16'h1234);
		wr16(tcc_pkg::ADDR_COUNT_LO, 16'h5678);
		tcc_pin_model_inst.setPin(0, 1'h1);
		rd16(4'h8, w);
		chkWord(w, 16'h0000);
		tcc_pin_model_inst.setPin(0, 1'h0);
		rd16(4'h8, w);
		chkWord(w, 16'h5678);
		wr16(tcc_pkg::ADDR_COUNT_LO, 16'h0ABC);
		wr(4'hA, 8'h00);
		rd16(4'hA, w);
		chkWord(w, 16'h0ABC);
		rd(tcc_pkg::ADDR_EVENTS, b);
		chkWord({8'h00, b & 8'h22}, 16'h0000);
		chkBit(b[7], 1'h1);
		// Trigger reload with and without the flag enable.
		wr(tcc_pkg::ADDR_CHMODE, 8'h00);
		wr16(4'h8, 16'h2222);
		wr(tcc_pkg::ADDR_STATUS, 8'h03);
		wr(tcc_pkg::ADDR_CTRL, 8'h58);
		tcc_pin_model_inst.setPin(5, 1'h0);
		tcc_pin_model_inst.setPin(5, 1'h1);
		rd16(tcc_pkg::ADDR_COUNT_LO, w);
		chkWord(w, 16'h2222);
		chkBit(externalReloadFlag, 1'h1);
		wr(tcc_pkg::ADDR_STATUS, 8'h03);
		wr(tcc_pkg::ADDR_CTRL, 8'h18);
		wr16(tcc_pkg::ADDR_COUNT_LO, 16'h0000);
		tcc_pin_model_inst.setPin(5, 1'h0);
		tcc_pin_model_inst.setPin(5, 1'h1);
		rd16(tcc_pkg::ADDR_COUNT_LO, w);
		chkWord(w, 16'h2222);
		chkBit(externalReloadFlag, 1'h0);
		// Rollover reload with compare mode 0 on ch1 and mode 1 on ch2.
		wr16(4'h8, 16'hFFF0);
		wr16(4'hA, 16'hFFF8);
		wr16(4'hC, 16'hFFF4);
		wr(tcc_pkg::ADDR_CHMODE, 8'h14);
		wr(tcc_pkg::ADDR_CMPSEL, 8'h04);
		wr(tcc_pkg::ADDR_PORT, 8'h00);
		wr16(tcc_pkg::ADDR_COUNT_LO, 16'hFFF0);
		wr(tcc_pkg::ADDR_STATUS, 8'h03);
		wr(tcc_pkg::ADDR_CTRL, 8'h09);
		waitObs(4, 1'h1);
		rd16(tcc_pkg::ADDR_COUNT_LO, w);
		chkWord({8'h00, w[15:8]}, 16'h00FF);
		waitObs(1, 1'h1);
		wr(tcc_pkg::ADDR_PORT, 8'h04);
		// Look at the pins once the write edge has taken effect.
		#1;
		chkBit(compareOut[1], 1'h1);
		chkBit(compareOut[2], 1'h0);
		waitObs(1, 1'h0);
		waitObs(2, 1'h1);
		wrap_up();
	end
endmodule
